//--- rtl/sep_pkg.sv
// Shared constants and types for the serial memory bus slave
package sep_pkg;

  // Storage shape: two pages of 256 bytes
  localparam int SEP_PAGES = 2;
  localparam int SEP_PAGE_BYTES = 256;
  localparam int SEP_MEM_BYTES = SEP_PAGES * SEP_PAGE_BYTES;
  localparam int SEP_LATCH_BYTES = 8;

  // Slave address field positions
  localparam int SEP_ID_MSB = 7;
  localparam int SEP_ID_LSB = 4;
  localparam int SEP_STRAP_HI_POS = 3;
  localparam int SEP_STRAP_LO_POS = 2;
  localparam int SEP_PAGE_POS = 1;
  localparam int SEP_RW_POS = 0;

  // Device type code; value is arbitrary
  localparam logic [3:0] SEP_TYPE_ID = 4'h6;

  // Bit counter value of the acknowledge slot
  localparam logic [3:0] SEP_ACK_SLOT = 4'h8;
  localparam logic [3:0] SEP_LAST_BIT = 4'h7;

  // Program cycle timing, typical and longest, in microseconds
  localparam int SEP_SYS_MHZ = 100;
  localparam int SEP_PROG_TYP_US = 5000;
  localparam int SEP_PROG_MAX_US = 10000;
  localparam int SEP_PROG_CYCLES = SEP_PROG_TYP_US * SEP_SYS_MHZ;
  localparam int SEP_PROG_MAX_CYCLES = SEP_PROG_MAX_US * SEP_SYS_MHZ;
  localparam int SEP_TIMER_W = 20;

  // Reset values
  localparam logic [7:0] SEP_ADDR_RST = 8'h00;
  localparam logic [7:0] SEP_BYTE_RST = 8'h00;

  // Protocol engine states
  typedef enum logic [2:0] {
    SEP_ST_IDLE,
    SEP_ST_DEV,
    SEP_ST_WADDR,
    SEP_ST_WDATA,
    SEP_ST_RDATA,
    SEP_ST_WAIT
  } sep_state_t;

  // One received write byte with its destination
  typedef struct packed {
    logic page;
    logic [7:0] addr;
    logic [7:0] data;
  } sep_word_t;

endpackage

//--- rtl/sep_link_sampler.sv
// Serial clock domain bit sampler with toggle event toward the system side
`timescale 1ns/1ns
module sep_link_sampler (
  // Link clock and reset
  input wire logic scl_clk,
  input wire logic arst_n,
  // Data line level
  input wire logic sda_i,
  // Sampled bit and event toggle
  output logic bit_q,
  output logic tog_q
);

  // Bit taken on the rising serial clock edge; it then holds for a whole
  // clock period, so the system side can read it after the toggle arrives
  always_ff @(posedge scl_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_q <= 1'b0;
      tog_q <= 1'b0;
    end
    else
    begin
      bit_q <= sda_i;
      tog_q <= ~tog_q;
    end
  end

endmodule

//--- rtl/sep_bus_slave.sv
// Two-wire bus slave front end with 512-byte store and timed program cycle
`timescale 1ns/1ns
module sep_bus_slave #(
  parameter int PROG_CYCLES = sep_pkg::SEP_PROG_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial clock, also the link domain clock
  input wire logic scl_clk,
  // Data line, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps
  input wire logic unused_addr_strap,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  // Program cycle status
  output logic prog_busy
);
  import sep_pkg::*;

  // Synchronisers and edge history
  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic tog_s1_q, tog_s2_q, tog_p_q;
  logic slo_s1_q, slo_s2_q, shi_s1_q, shi_s2_q;
  // Link sampler outputs
  logic link_bit, link_tog;
  // Decoded bus events
  logic scl_fall, start_evt, stop_evt, bit_evt;
  // Engine state
  sep_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, addr_q, tx_q;
  logic page_q, rw_q, ack_q, sda_oe_q;
  logic [7:0] byte_in;
  // Write word path
  logic wr_valid_q, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  sep_word_t wr_word_q, fifo_out;
  sep_word_t fifo_mem_q [2];
  logic fifo_wp_q, fifo_rp_q;
  logic [1:0] fifo_cnt_q;
  // Page latch and program timer
  logic [7:0] latch_q [SEP_LATCH_BYTES];
  logic [SEP_LATCH_BYTES-1:0] mask_q;
  logic [5:0] base_q;
  logic busy_q, commit;
  logic [SEP_TIMER_W-1:0] timer_q;
  // Nonvolatile array
  logic [7:0] mem_q [SEP_MEM_BYTES];

  // Address match; the lowest strap is never consulted
  function automatic logic dev_match(input logic [7:0] b, input logic lo, input logic hi);
    dev_match = (b[SEP_ID_MSB:SEP_ID_LSB] == SEP_TYPE_ID) && (b[SEP_STRAP_HI_POS] == hi)
      && (b[SEP_STRAP_LO_POS] == lo);
  endfunction

  sep_link_sampler u_link (
    .scl_clk(scl_clk),
    .arst_n(arst_n),
    .sda_i(sda_i),
    .bit_q(link_bit),
    .tog_q(link_tog)
  );

  // Pin and toggle synchronisers; first stages feed only second stages
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'b111;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'b111;
      {tog_s1_q, tog_s2_q, tog_p_q} <= 3'b000;
      {slo_s1_q, slo_s2_q, shi_s1_q, shi_s2_q} <= 4'h0;
    end
    else
    begin
      scl_s1_q <= scl_clk;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
      tog_s1_q <= link_tog;
      tog_s2_q <= tog_s1_q;
      tog_p_q <= tog_s2_q;
      slo_s1_q <= addr_strap_low;
      slo_s2_q <= slo_s1_q;
      shi_s1_q <= addr_strap_high;
      shi_s2_q <= shi_s1_q;
    end
  end

  // Start and stop are data edges while the clock is high
  assign scl_fall = scl_p_q & ~scl_s2_q;
  assign start_evt = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_evt = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign bit_evt = tog_s2_q ^ tog_p_q;
  assign byte_in = {shift_q[6:0], link_bit};

  // Protocol engine: advances only on sampled bits, start and stop
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SEP_ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= SEP_BYTE_RST;
      addr_q <= SEP_ADDR_RST;
      tx_q <= SEP_BYTE_RST;
      page_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_word_q <= '0;
    end
    else
    begin
      wr_valid_q <= 1'b0;
      if (start_evt)
      begin
        // Busy device treats every frame as foreign
        state_q <= busy_q ? SEP_ST_WAIT : SEP_ST_DEV;
        cnt_q <= 4'h0;
      end
      else if (stop_evt)
        state_q <= SEP_ST_IDLE;
      else if (bit_evt)
      begin
        unique case (state_q)
          SEP_ST_IDLE, SEP_ST_WAIT:
            cnt_q <= 4'h0;
          SEP_ST_DEV, SEP_ST_WADDR, SEP_ST_WDATA:
          begin
            if (cnt_q != SEP_ACK_SLOT)
            begin
              shift_q <= byte_in;
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == SEP_LAST_BIT)
              begin
                // Whole byte in: decide the acknowledge
                if (state_q == SEP_ST_DEV)
                begin
                  ack_q <= dev_match(byte_in, slo_s2_q, shi_s2_q);
                  page_q <= byte_in[SEP_PAGE_POS];
                  rw_q <= byte_in[SEP_RW_POS];
                end
                else if (state_q == SEP_ST_WADDR)
                begin
                  ack_q <= 1'b1;
                  addr_q <= byte_in;
                end
                else
                begin
                  // A full buffer refuses the byte by not acknowledging
                  ack_q <= fifo_in_ready;
                  wr_valid_q <= fifo_in_ready;
                  wr_word_q <= '{page: page_q, addr: addr_q, data: byte_in};
                  if (fifo_in_ready)
                    addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
                end
              end
            end
            else
            begin
              cnt_q <= 4'h0;
              if (!ack_q)
                state_q <= SEP_ST_WAIT;
              else if (state_q == SEP_ST_DEV && rw_q)
              begin
                state_q <= SEP_ST_RDATA;
                tx_q <= mem_q[{page_q, addr_q}];
                addr_q <= addr_q + 8'h01;
              end
              else if (state_q == SEP_ST_DEV)
                state_q <= SEP_ST_WADDR;
              else
                state_q <= SEP_ST_WDATA;
            end
          end
          SEP_ST_RDATA:
          begin
            if (cnt_q != SEP_ACK_SLOT)
              cnt_q <= cnt_q + 4'h1;
            else if (!link_bit)
            begin
              // Master acknowledged: next byte, wrapping inside the page
              cnt_q <= 4'h0;
              tx_q <= mem_q[{page_q, addr_q}];
              addr_q <= addr_q + 8'h01;
            end
            else
              state_q <= SEP_ST_WAIT;
          end
        endcase
      end
    end
  end

  // Line driver: pulls low only after a clock fall, releases there or at start and stop
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sda_oe_q <= 1'b0;
    else if (start_evt || stop_evt)
      sda_oe_q <= 1'b0;
    else if (scl_fall)
    begin
      unique case (state_q)
        SEP_ST_DEV, SEP_ST_WADDR, SEP_ST_WDATA:
          sda_oe_q <= (cnt_q == SEP_ACK_SLOT) && ack_q;
        SEP_ST_RDATA:
          sda_oe_q <= (cnt_q != SEP_ACK_SLOT) && !tx_q[3'(4'd7 - cnt_q)];
        default:
          sda_oe_q <= 1'b0;
      endcase
    end
  end

  // Two-entry buffer between the engine and the page latch
  assign fifo_in_ready = (fifo_cnt_q != 2'd2);
  assign fifo_out_valid = (fifo_cnt_q != 2'd0);
  assign fifo_out_ready = !busy_q;
  assign fifo_out = fifo_mem_q[fifo_rp_q];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'd0;
      fifo_mem_q[0] <= '0;
      fifo_mem_q[1] <= '0;
    end
    else
    begin
      if (wr_valid_q && fifo_in_ready)
      begin
        fifo_mem_q[fifo_wp_q] <= wr_word_q;
        fifo_wp_q <= ~fifo_wp_q;
      end
      if (fifo_out_valid && fifo_out_ready)
        fifo_rp_q <= ~fifo_rp_q;
      fifo_cnt_q <= fifo_cnt_q + 2'(wr_valid_q && fifo_in_ready)
        - 2'(fifo_out_valid && fifo_out_ready);
    end
  end

  // Page latch collects up to eight bytes; overflow overwrites earlier ones
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_q <= '0;
      base_q <= 6'h00;
      for (int i = 0; i < SEP_LATCH_BYTES; i++)
        latch_q[i] <= SEP_BYTE_RST;
    end
    else if (commit)
      mask_q <= '0;
    else if (fifo_out_valid && fifo_out_ready)
    begin
      latch_q[fifo_out.addr[2:0]] <= fifo_out.data;
      mask_q[fifo_out.addr[2:0]] <= 1'b1;
      base_q <= {fifo_out.page, fifo_out.addr[7:3]};
    end
  end

  // Program timer: starts at stop with pending bytes, fixed length
  assign commit = busy_q && (timer_q == SEP_TIMER_W'(PROG_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      timer_q <= '0;
    end
    else if (!busy_q)
    begin
      timer_q <= '0;
      if (stop_evt && (mask_q != '0 || fifo_out_valid))
        busy_q <= 1'b1;
    end
    else if (commit)
      busy_q <= 1'b0;
    else
      timer_q <= timer_q + SEP_TIMER_W'(1);
  end

  // Array update at the end of the program cycle
  always_ff @(posedge clk_sys)
  begin
    if (commit)
      for (int i = 0; i < SEP_LATCH_BYTES; i++)
        if (mask_q[i])
          mem_q[{base_q, 3'(i)}] <= latch_q[i];
  end

  // Outputs straight from flip-flops; the line is never driven high
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end
  assign sda_oe = sda_oe_q;
  assign prog_busy = busy_q;

  // Checks
  a_line_never_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sda_oe |-> !sda_o) else $error("data line driven high");
  a_busy_silent: assert property (@(posedge clk_sys) disable iff (!arst_n)
    busy_q && start_evt |=> state_q == SEP_ST_WAIT ##1 (!sda_oe_q)[*8])
    else $error("busy device answered");
  a_prog_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
    busy_q |-> (int'(timer_q) < PROG_CYCLES) && (PROG_CYCLES <= SEP_PROG_MAX_CYCLES))
    else $error("program cycle overran");
  a_prog_end_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(busy_q) |-> int'($past(timer_q)) == PROG_CYCLES - 1)
    else $error("program cycle ended early");
  a_prog_at_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(busy_q) |-> $past(stop_evt)) else $error("program began without stop");
  a_wr_low_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(wr_valid_q) || (wr_valid_q && $past(wr_valid_q)) |->
    addr_q == {$past(addr_q[7:3]), $past(addr_q[2:0]) + 3'h1})
    else $error("write address step wrong");
  a_rd_full_inc: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bit_evt && state_q == SEP_ST_RDATA && cnt_q == SEP_ACK_SLOT && !link_bit
    |=> addr_q == $past(addr_q) + 8'h01 && state_q == SEP_ST_RDATA)
    else $error("read address step wrong");
  a_ack_needs_match: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_q == SEP_ST_DEV && cnt_q == SEP_ACK_SLOT && ack_q |->
    shift_q[SEP_ID_MSB:SEP_ID_LSB] == SEP_TYPE_ID && shift_q[SEP_STRAP_HI_POS] == shi_s2_q
    && shift_q[SEP_STRAP_LO_POS] == slo_s2_q)
    else $error("acknowledged foreign address");
  a_drive_on_fall: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(sda_oe_q) |-> $past(scl_fall)) else $error("line pulled off clock fall");

endmodule

//--- test/sep_bus_master.sv
// Behavioural two-wire bus master model for the serial memory slave
`timescale 1ns/1ns
module sep_bus_master (
  // Serial clock, held high between frames
  output logic scl,
  // Data pull-down, high pulls the line low
  output logic sda_oe,
  // Resolved data line
  input wire logic sda
);
  // Quarter bit: six 10 ns system clock periods, so the slave sync keeps up
  localparam int Q = 60;

  // Idle bus: clock high, line released
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Start from idle, or repeated start with the clock low
  task automatic start();
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
  endtask

  // Stop, then the clock stands still
  task automatic stop();
    #Q sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #Q;
  endtask

  // One clock pulse: data set while low, sampled while high
  task automatic bit_io(input logic b, output logic s);
    #Q sda_oe = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask

  // Byte out MSB first, then the slave's acknowledge slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in MSB first, then our acknowledge or refusal
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

//--- test/tb_serial_eeprom_bus_slave.sv
// Self-checking bench for the serial memory bus slave
`timescale 1ns/1ns
module tb_serial_eeprom_bus_slave;
  import sep_pkg::*;
  // Short program cycle keeps the run brief
  localparam int PROG = 2000;
  logic clk_sys, arst_n, scl_clk, m_oe, sda_i, sda_o, sda_oe, prog_busy;
  logic unused_addr_strap, addr_strap_low, addr_strap_high;
  int bad_count, n_checks, busy_len;

  // Pull-up on the shared data line
  assign sda_i = ~(m_oe | sda_oe);

  sep_bus_slave #(.PROG_CYCLES(PROG)) dut (.clk_sys, .arst_n, .scl_clk, .sda_i,
    .sda_o, .sda_oe, .unused_addr_strap, .addr_strap_low, .addr_strap_high,
    .prog_busy);
  sep_bus_master u_mst (.scl(scl_clk), .sda_oe(m_oe), .sda(sda_i));

  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Length of the latest program cycle
  always @(posedge clk_sys)
  begin
    if (prog_busy === 1'b1)
      busy_len <= busy_len + 1;
  end

  // Line only ever pulled low; silent while programming
  always @(negedge clk_sys)
  begin
    if (sda_oe === 1'b1)
      chk("sda_o", 8'h00, {7'h0, sda_o});
    if (prog_busy === 1'b1)
      chk("busy_oe", 8'h00, {7'h0, sda_oe});
  end

  // Compare and count
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // Slave address byte for this device
  function automatic logic [7:0] dev(logic pg, logic rd);
    return {SEP_TYPE_ID, addr_strap_high, addr_strap_low, pg, rd};
  endfunction

  // Addressed write of a byte list ending in a stop
  task automatic wr(logic pg, logic [7:0] a, logic [7:0] d[$]);
    logic ack;
    u_mst.start();
    u_mst.wbyte(dev(pg, 1'b0), ack);
    chk("dev_ack", 8'h01, {7'h0, ack});
    u_mst.wbyte(a, ack);
    chk("addr_ack", 8'h01, {7'h0, ack});
    foreach (d[i])
    begin
      u_mst.wbyte(d[i], ack);
      chk("data_ack", 8'h01, {7'h0, ack});
    end
    busy_len = 0;
    u_mst.stop();
  endtask

  // Bounded wait for the program cycle, then its length
  task automatic wait_prog();
    int i;
    for (i = 0; i < PROG + 500 && prog_busy !== 1'b0; i++)
      @(negedge clk_sys);
    if (i == PROG + 500)
    begin
      $display("ERROR prog_wait expected %h seen %h", 1'b0, prog_busy);
      bad_count++;
      results();
    end
    chk("prog_len", 8'h01, 8'(busy_len >= PROG - 4 && busy_len <= PROG + 4));
  endtask

  // Dummy write to a, repeated start, bytes read and compared
  task automatic rd(logic pg, logic [7:0] a, logic [7:0] e[$]);
    logic ack;
    logic [7:0] b;
    u_mst.start();
    u_mst.wbyte(dev(pg, 1'b0), ack);
    u_mst.wbyte(a, ack);
    u_mst.start();
    u_mst.wbyte(dev(pg, 1'b1), ack);
    chk("rd_ack", 8'h01, {7'h0, ack});
    foreach (e[i])
    begin
      u_mst.rbyte(i < e.size() - 1, b);
      chk("rd_data", e[i], b);
    end
    u_mst.stop();
  endtask

  // Byte write; polling refused while the program cycle runs
  task automatic t_byte_write();
    logic ack;
    wr(1'b0, 8'h10, '{8'hA5});
    u_mst.start();
    u_mst.wbyte(dev(1'b0, 1'b0), ack);
    chk("poll_ack", 8'h00, {7'h0, ack});
    u_mst.stop();
    wait_prog();
    rd(1'b0, 8'h10, '{8'hA5});
  endtask

  // Nine bytes from 0x1E: low three bits wrap, ninth overwrites first
  task automatic t_page_wrap();
    wr(1'b1, 8'h1E, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h09});
    wait_prog();
    rd(1'b1, 8'h18, '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h02});
    rd(1'b0, 8'h10, '{8'hA5});
  endtask

  // Sequential read wraps from 0xFF to 0x00 of the same page
  task automatic t_read_wrap();
    wr(1'b1, 8'hFF, '{8'h3C});
    wait_prog();
    wr(1'b1, 8'h00, '{8'hC3});
    wait_prog();
    rd(1'b1, 8'hFF, '{8'h3C, 8'hC3});
  endtask

  // Wrong type or strap bits refused; lowest strap has no effect
  task automatic t_straps();
    logic ack;
    logic [7:0] flip[3] = '{8'h80, 8'h08, 8'h04};
    @(negedge clk_sys);
    unused_addr_strap = 1'b1;
    foreach (flip[i])
    begin
      u_mst.start();
      u_mst.wbyte(dev(1'b0, 1'b0) ^ flip[i], ack);
      chk("bad_addr_ack", 8'h00, {7'h0, ack});
      u_mst.stop();
    end
    rd(1'b0, 8'h10, '{8'hA5});
  endtask

  // Read without word address continues after the last byte read
  task automatic t_cur_read();
    logic ack;
    logic [7:0] b;
    rd(1'b1, 8'h18, '{8'h03, 8'h04});
    u_mst.start();
    u_mst.wbyte(dev(1'b1, 1'b1), ack);
    chk("cur_ack", 8'h01, {7'h0, ack});
    u_mst.rbyte(1'b0, b);
    u_mst.stop();
    chk("cur_data", 8'h05, b);
  endtask

  // Reset during a program cycle ends it; stored bytes survive
  task automatic t_mid_reset();
    wr(1'b0, 8'h20, '{8'h5A});
    @(negedge clk_sys);
    chk("busy_pre_rst", 8'h01, {7'h0, prog_busy});
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("busy_post_rst", 8'h00, {7'h0, prog_busy});
    repeat (6) @(negedge clk_sys);
    rd(1'b0, 8'h10, '{8'hA5});
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    arst_n = 1'b0;
    unused_addr_strap = 1'b0;
    addr_strap_low = 1'b1;
    addr_strap_high = 1'b0;
    bad_count = 0;
    n_checks = 0;
    busy_len = 0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("rst_busy", 8'h00, {7'h0, prog_busy});
    t_byte_write();
    t_page_wrap();
    t_read_wrap();
    t_straps();
    t_cur_read();
    t_mid_reset();
    results();
  end
endmodule
